//--- design/audio_port_mute_source_select.sv
// mute source selector registers for the second and third audio ports
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "mute_select_regs.svh"

module audio_port_mute_source_select
	import mute_select_pkg::*;
#(
	parameter bit has_third_port = 1'b1
)
(
	input  wire logic                           clock,
	input  wire logic                           reset,
	input  wire logic                           clock_enable,
	input  wire mute_select_pkg::reg_request_type request,
	output logic [31:0]                         read_data,
	input  wire mute_select_pkg::mute_pins_type   pins,
	output logic                                port1_mute,
	output logic                                port2_mute
);

	mute_source_type port1_mute_source_sel;
	mute_source_type port2_mute_source_sel;
	mute_source_type next_port1_sel;
	mute_source_type next_port2_sel;
	mute_source_type port2_effective_sel;
	logic [31:0]     next_read_data;
	logic            hit_port1;
	logic            hit_port2;

	// ==========================================================
	// address decode
	always_comb
	begin
		hit_port1 = 1'b0;
		hit_port2 = 1'b0;
		if (request.address == `PORT1_MUTE_CFG_OFFSET)
			hit_port1 = 1'b1;
		else if (request.address == `PORT2_MUTE_CFG_OFFSET)
			hit_port2 = has_third_port;
	end

	// ==========================================================
	// selector registers
	always_comb
	begin
		next_port1_sel = port1_mute_source_sel;
		next_port2_sel = port2_mute_source_sel;
		// reserved upper bits are dropped on write
		if (request.write_strobe && hit_port1)
			next_port1_sel = mute_source_type'(
				request.write_data[`MUTE_SEL_MSB:`MUTE_SEL_LSB]);
		if (request.write_strobe && hit_port2)
			next_port2_sel = mute_source_type'(
				request.write_data[`MUTE_SEL_MSB:`MUTE_SEL_LSB]);
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			port1_mute_source_sel <= mute_source_type'(`MUTE_SEL_RESET);
			port2_mute_source_sel <= mute_source_type'(`MUTE_SEL_RESET);
		end
		else if (clock_enable)
		begin
			port1_mute_source_sel <= next_port1_sel;
			port2_mute_source_sel <= next_port2_sel;
		end
	end

	// ==========================================================
	// read path, data valid the cycle after the read strobe
	always_comb
	begin
		next_read_data = `MUTE_UNMAPPED_READ;
		if (request.read_strobe && hit_port1)
			next_read_data = {29'h0, port1_mute_source_sel};
		else if (request.read_strobe && hit_port2)
			next_read_data = {29'h0, port2_mute_source_sel};
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			read_data <= `MUTE_UNMAPPED_READ;
		else if (clock_enable)
			read_data <= next_read_data;
	end

	// ==========================================================
	// multiplexers
	// a missing third port keeps its mute at constant zero
	assign port2_effective_sel = has_third_port ? port2_mute_source_sel
		: sel_constant_zero;

	mute_source_mux port1_mux
	(
		.clock        (clock),
		.reset        (reset),
		.clock_enable (clock_enable),
		.select       (port1_mute_source_sel),
		.pins         (pins),
		.mute         (port1_mute)
	);

	mute_source_mux port2_mux
	(
		.clock        (clock),
		.reset        (reset),
		.clock_enable (clock_enable),
		.select       (port2_effective_sel),
		.pins         (pins),
		.mute         (port2_mute)
	);

	// ==========================================================
	// checks
	write_port1_a: assert property (@(posedge clock) disable iff (reset)
		clock_enable && request.write_strobe && hit_port1
		|=> port1_mute_source_sel == $past(request.write_data[2:0]))
		else $error("port one selector write lost");

	write_port2_a: assert property (@(posedge clock) disable iff (reset)
		clock_enable && request.write_strobe && hit_port2
		|=> port2_mute_source_sel == $past(request.write_data[2:0]))
		else $error("port two selector write lost");

	reserved_zero_a: assert property (@(posedge clock) disable iff (reset)
		clock_enable && request.read_strobe |=> read_data[31:3] == 29'h0)
		else $error("reserved bits read nonzero");

	readback_a: assert property (@(posedge clock) disable iff (reset)
		clock_enable && request.read_strobe && hit_port1
		|=> read_data[2:0] == $past(port1_mute_source_sel))
		else $error("port one readback wrong");

	no_third_port_a: assert property (@(posedge clock) disable iff (reset)
		!has_third_port |-> ##1 !port2_mute)
		else $error("absent port mute not zero");

	reset_value_a: assert property (@(posedge clock)
		reset |=> port1_mute_source_sel == sel_constant_zero
		&& port2_mute_source_sel == sel_constant_zero && !port1_mute)
		else $error("selectors not cleared by reset");

	route_pin_a: assert property (@(posedge clock) disable iff (reset)
		clock_enable && port1_mute_source_sel == sel_port2_hrx_clk
		|=> port1_mute == $past(pins.port2_high_rate_rx_clock))
		else $error("receive clock not routed");

	freeze_a: assert property (@(posedge clock) disable iff (reset)
		!clock_enable |=> $stable(port1_mute_source_sel) && $stable(read_data))
		else $error("state moved with clock enable low");

	// ==========================================================
	// checks: per code routing and register access
	for (genvar code = 1; code < 8; code++)
	begin : gen_route
		route_port1_a: assert property (@(posedge clock) disable iff (reset)
			clock_enable && port1_mute_source_sel == mute_source_type'(code)
			|=> port1_mute == $past(pins[code - 1]))
			else $error("port one mute not routed");

		route_port2_a: assert property (@(posedge clock) disable iff (reset)
			clock_enable && has_third_port
			&& port2_mute_source_sel == mute_source_type'(code)
			|=> port2_mute == $past(pins[code - 1]))
			else $error("port two mute not routed");
	end

	for (genvar code = 0; code < 8; code++)
	begin : gen_code
		code_write1_a: assert property (@(posedge clock) disable iff (reset)
			clock_enable && request.write_strobe && hit_port1
			&& request.write_data[2:0] == 3'(code)
			|=> port1_mute_source_sel == mute_source_type'(code))
			else $error("port one code not stored");

		code_write2_a: assert property (@(posedge clock) disable iff (reset)
			clock_enable && request.write_strobe && hit_port2
			&& request.write_data[2:0] == 3'(code)
			|=> port2_mute_source_sel == mute_source_type'(code))
			else $error("port two code not stored");

		code_read1_a: assert property (@(posedge clock) disable iff (reset)
			clock_enable && request.read_strobe && hit_port1
			&& port1_mute_source_sel == mute_source_type'(code)
			|=> read_data == 32'(code))
			else $error("port one code not read back");

		code_read2_a: assert property (@(posedge clock) disable iff (reset)
			clock_enable && request.read_strobe && hit_port2
			&& port2_mute_source_sel == mute_source_type'(code)
			|=> read_data == 32'(code))
			else $error("port two code not read back");
	end

	// ==========================================================
	// checks: decode and read path
	readback_two_a: assert property (@(posedge clock) disable iff (reset)
		clock_enable && request.read_strobe && hit_port2
		|=> read_data[2:0] == $past(port2_mute_source_sel))
		else $error("port two readback wrong");

	read_idle_a: assert property (@(posedge clock) disable iff (reset)
		clock_enable && !request.read_strobe |=> read_data == 32'h0000_0000)
		else $error("read data not idle");

	read_unmapped_a: assert property (@(posedge clock) disable iff (reset)
		clock_enable && request.read_strobe && !hit_port1 && !hit_port2
		|=> read_data == 32'h0000_0000)
		else $error("unmapped read nonzero");

	lite_read_a: assert property (@(posedge clock) disable iff (reset)
		clock_enable && !has_third_port && request.read_strobe
		&& request.address == `PORT2_MUTE_CFG_OFFSET
		|=> read_data == 32'h0000_0000)
		else $error("absent port register readable");

	lite_sel_a: assert property (@(posedge clock) disable iff (reset)
		!has_third_port |-> port2_mute_source_sel == sel_constant_zero)
		else $error("absent port selector written");

	lite_effective_a: assert property (@(posedge clock)
		!has_third_port |-> port2_effective_sel == sel_constant_zero)
		else $error("absent port selection not zero");

	effective_a: assert property (@(posedge clock)
		has_third_port |-> port2_effective_sel == port2_mute_source_sel)
		else $error("port two selection not passed on");

	hit_exclusive_a: assert property (@(posedge clock)
		!(hit_port1 && hit_port2))
		else $error("both selectors decoded");

	hit_decode_a: assert property (@(posedge clock)
		hit_port1 == (request.address == `PORT1_MUTE_CFG_OFFSET))
		else $error("port one decode wrong");

	write_no_read_a: assert property (@(posedge clock) disable iff (reset)
		clock_enable && request.write_strobe |=> read_data == 32'h0000_0000)
		else $error("write produced read data");

	// ==========================================================
	// checks: holding, freezing and reset
	unmapped_write_a: assert property (@(posedge clock) disable iff (reset)
		request.write_strobe && !hit_port1 && !hit_port2
		|=> $stable(port1_mute_source_sel) && $stable(port2_mute_source_sel))
		else $error("unmapped write changed a selector");

	hold_one_a: assert property (@(posedge clock) disable iff (reset)
		!(request.write_strobe && hit_port1) |=> $stable(port1_mute_source_sel))
		else $error("port one selector moved");

	hold_two_a: assert property (@(posedge clock) disable iff (reset)
		!(request.write_strobe && hit_port2) |=> $stable(port2_mute_source_sel))
		else $error("port two selector moved");

	freeze_two_a: assert property (@(posedge clock) disable iff (reset)
		!clock_enable |=> $stable(port2_mute_source_sel))
		else $error("port two selector moved while frozen");

	freeze_mute_a: assert property (@(posedge clock) disable iff (reset)
		!clock_enable |=> $stable(port1_mute) && $stable(port2_mute))
		else $error("mute moved while frozen");

	zero_one_a: assert property (@(posedge clock) disable iff (reset)
		clock_enable && port1_mute_source_sel == sel_constant_zero
		|=> !port1_mute)
		else $error("port one mute not zero");

	zero_two_a: assert property (@(posedge clock) disable iff (reset)
		clock_enable && port2_effective_sel == sel_constant_zero
		|=> !port2_mute)
		else $error("port two mute not zero");

	reset_two_a: assert property (@(posedge clock)
		reset |=> !port2_mute && read_data == 32'h0000_0000)
		else $error("port two or read data not cleared");

	freeze_cover: cover property (@(posedge clock)
		!clock_enable && request.write_strobe && hit_port1);
	code7_cover: cover property (@(posedge clock)
		port1_mute_source_sel == sel_spi_enable && port1_mute);
	write_cover: cover property (@(posedge clock)
		request.write_strobe && hit_port2);
	read_cover: cover property (@(posedge clock)
		request.read_strobe && hit_port1);
	mute_cover: cover property (@(posedge clock) port1_mute && port2_mute);

endmodule

`default_nettype wire

//--- design/mute_source_mux.sv
// one registered eight-way mute source multiplexer
`timescale 1ns/100ps
`default_nettype none

module mute_source_mux
	import mute_select_pkg::*;
(
	input  wire logic                           clock,
	input  wire logic                           reset,
	input  wire logic                           clock_enable,
	input  wire mute_select_pkg::mute_source_type select,
	input  wire mute_select_pkg::mute_pins_type   pins,
	output logic                                mute
);

	logic next_mute;

	// ==========================================================
	// selection
	always_comb
	begin
		case (select)
			sel_constant_zero:  next_mute = 1'b0;
			sel_data7_spi_clk:  next_mute = pins.data7_spi_clock_pin;
			sel_data8:          next_mute = pins.data8_pin;
			sel_data9:          next_mute = pins.data9_pin;
			sel_port2_hrx_clk:  next_mute = pins.port2_high_rate_rx_clock;
			sel_spi_master_out: next_mute = pins.first_spi_master_out_pin;
			sel_spi_chip_sel:   next_mute = pins.first_spi_chip_select_pin;
			default:            next_mute = pins.first_spi_enable_pin;
		endcase
	end

	// registered so the mute output is a flip-flop, one cycle behind pins
	always_ff @(posedge clock)
	begin
		if (reset)
			mute <= 1'b0;
		else if (clock_enable)
			mute <= next_mute;
	end

	mux_zero_a: assert property (@(posedge clock) disable iff (reset)
		clock_enable && select == sel_constant_zero |=> !mute)
		else $error("mute not zero for constant selection");

	mux_route_a: assert property (@(posedge clock) disable iff (reset)
		clock_enable && select != sel_constant_zero
		|=> mute == $past(pins[select - 3'h1]))
		else $error("mute does not follow the selected pin");

endmodule

`default_nettype wire

//--- include/mute_select_pkg.sv
// types shared by the mute source selector design
package mute_select_pkg;

	typedef enum logic [2:0]
	{
		sel_constant_zero  = 3'h0,
		sel_data7_spi_clk  = 3'h1,
		sel_data8          = 3'h2,
		sel_data9          = 3'h3,
		sel_port2_hrx_clk  = 3'h4,
		sel_spi_master_out = 3'h5,
		sel_spi_chip_sel   = 3'h6,
		sel_spi_enable     = 3'h7
	} mute_source_type;

	// the seven selectable device pins, listed from code 7 down to code 1 (bit 0 is code 1)
	typedef struct packed
	{
		logic first_spi_enable_pin;
		logic first_spi_chip_select_pin;
		logic first_spi_master_out_pin;
		logic port2_high_rate_rx_clock;
		logic data9_pin;
		logic data8_pin;
		logic data7_spi_clock_pin;
	} mute_pins_type;

	typedef struct packed
	{
		logic [31:0] address;
		logic [31:0] write_data;
		logic        write_strobe;
		logic        read_strobe;
	} reg_request_type;

endpackage

//--- include/mute_select_regs.svh
// register offsets, field positions and reset values of the mute source selectors
`ifndef MUTE_SELECT_REGS_SVH
`define MUTE_SELECT_REGS_SVH

`define PORT1_MUTE_CFG_OFFSET   32'h4000_001c
`define PORT2_MUTE_CFG_OFFSET   32'h4000_0020
`define MUTE_SEL_LSB            0
`define MUTE_SEL_MSB            2
`define MUTE_SEL_RESET          3'h0
`define MUTE_UNMAPPED_READ      32'h0000_0000

`endif

//--- tb/mute_pin_model.sv
// far-side model driving the seven selectable mute source pins
`timescale 1ns/100ps
`default_nettype none

module mute_pin_model
	import mute_select_pkg::*;
(
	input  wire logic                       clock,
	input  wire logic                       reset,
	output mute_select_pkg::mute_pins_type  pins
);
	// ==========
	// pin pattern
	// odd step so every pin toggles within a few cycles
	always_ff @(posedge clock)
	begin
		if (reset)
			pins <= mute_pins_type'(7'h2a);
		else
			pins <= mute_pins_type'(pins + 7'h25);
	end
endmodule

`default_nettype wire

//--- tb/test_audio_port_mute_source_select.sv
// self-checking bench for the mute source selectors
`timescale 1ns/100ps
`default_nettype none
`include "mute_select_regs.svh"

module test_audio_port_mute_source_select;
	import mute_select_pkg::*;
	logic             clock = 1'b0;
	logic             reset = 1'b1;
	logic             clock_enable = 1'b1;
	reg_request_type  request = '0;
	logic [31:0]      read_data;
	logic [31:0]      lite_read_data;
	mute_pins_type    pins;
	mute_pins_type    prev_pins;
	logic             port1_mute;
	logic             port2_mute;
	logic             lite_port2_mute;
	int               err_count = 0;
	int               n_tests = 0;

	always #5 clock = ~clock;
	always @(posedge clock) prev_pins <= pins;

	// ==========
	// instances
	// lite instance models the variant without the third port
	audio_port_mute_source_select #(.has_third_port(1'b1))
	u_audio_port_mute_source_select (.clock(clock), .reset(reset),
		.clock_enable(clock_enable), .request(request), .read_data(read_data),
		.pins(pins), .port1_mute(port1_mute), .port2_mute(port2_mute));
	audio_port_mute_source_select #(.has_third_port(1'b0))
	u_audio_port_mute_source_select_lite (.clock(clock), .reset(reset),
		.clock_enable(clock_enable), .request(request),
		.read_data(lite_read_data), .pins(pins), .port1_mute(),
		.port2_mute(lite_port2_mute));
	mute_pin_model u_mute_pin_model (.clock(clock), .reset(reset),
		.pins(pins));

	// ==========
	// tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] expected);
		n_tests++;
		if (seen !== expected)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
				expected);
		end
	endtask

	task automatic write_reg(input logic [31:0] address,
		input logic [31:0] data);
		@(posedge clock);
		request <= '{address, data, 1'b1, 1'b0};
		@(posedge clock);
		request.write_strobe <= 1'b0;
	endtask

	task automatic read_reg(input logic [31:0] address,
		output logic [31:0] main, output logic [31:0] lite);
		@(posedge clock);
		request <= '{address, 32'h0000_0000, 1'b0, 1'b1};
		@(posedge clock);
		request.read_strobe <= 1'b0;
		#1;
		main = read_data;
		lite = lite_read_data;
		@(posedge clock);
		#1;
		check(read_data, 32'h0000_0000);
	endtask

	function automatic logic pick(input logic [2:0] code, input mute_pins_type p);
		logic [6:0] bits;
		bits = p;
		return (code == 3'h0) ? 1'b0 : bits[code - 3'h1];
	endfunction

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ==========
	// main sequence
	initial
	begin
		logic [31:0] main_value;
		logic [31:0] lite_value;
		logic [31:0] address;
		for (int pass = 0; pass < 2; pass++)
		begin
			// second pass repeats reset in mid-run
			reset <= 1'b1;
			repeat (6) @(posedge clock);
			reset <= 1'b0;
			read_reg(`PORT1_MUTE_CFG_OFFSET, main_value, lite_value);
			check(main_value, 32'h0000_0000);
			read_reg(`PORT2_MUTE_CFG_OFFSET, main_value, lite_value);
			check(main_value, 32'h0000_0000);
			check({port1_mute, port2_mute}, 32'h0000_0000);
			for (int port = 0; port < 2 && pass == 0; port++)
				for (int code = 0; code < 8; code++)
				begin
					address = port ? `PORT2_MUTE_CFG_OFFSET : `PORT1_MUTE_CFG_OFFSET;
					// software keeps the reserved bits at zero
					write_reg(address, 32'(code));
					read_reg(address, main_value, lite_value);
					check(main_value, 32'(code));
					check(lite_value, port ? 32'h0000_0000 : 32'(code));
					repeat (3)
					begin
						@(negedge clock);
						check(port ? port2_mute : port1_mute, pick(3'(code), prev_pins));
						check(lite_port2_mute, 1'b0);
					end
				end
			// a write with the enable low must not land
			clock_enable <= 1'b0;
			write_reg(`PORT1_MUTE_CFG_OFFSET, 32'h0000_0001);
			clock_enable <= 1'b1;
			write_reg(32'h4000_0024, 32'h0000_0002);
			read_reg(32'h4000_0024, main_value, lite_value);
			check(main_value, 32'h0000_0000);
			read_reg(`PORT1_MUTE_CFG_OFFSET, main_value, lite_value);
			check(main_value, pass ? 32'h0000_0000 : 32'h0000_0007);
		end
		summarize();
	end
endmodule

`default_nettype wire
